// ---- verilog/ldq_pkg.sv ----
// Purpose: shared constants and types of the segment display driver
// Assumes: 100 MHz clock, 16-bit byte-addressed register port
// Notes:   offsets, field positions, reset values and timing counts
package ldq_pkg;

   // ----------------------------------------------------------------
   // bus carrier
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
      logic word;
   } ldq_bus_req_s;

   // ----------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------
   localparam logic [15:0] MEM_BASE = 16'hf370;
   localparam logic [15:0] MEM_LAST = 16'hf37f;
   localparam int MEM_BYTES = 16;
   localparam logic [15:0] CFG_BASE = 16'hffa0;
   localparam logic [15:0] CFG_LAST = 16'hffab;
   localparam int CFG_BYTES = 12;
   localparam logic [15:0] ODD_BYTE = 16'h0001;
   localparam logic [15:0] ADDR_PFS = 16'hffa0;
   localparam logic [15:0] ADDR_DSUP = 16'hffa2;

   // byte indices inside the configuration block
   localparam logic [3:0] IDX_PFS = 4'h0;
   localparam logic [3:0] IDX_DCTL = 4'h1;
   localparam logic [3:0] IDX_DSUP = 4'h2;
   localparam logic [3:0] IDX_STAT = 4'h3;
   localparam logic [3:0] IDX_PSEL = 4'h4;
   localparam logic [3:0] IDX_PDAT = 4'h8;

   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] MEM_RESET = 8'h00;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int PFS_DUTY_HI = 7;
   localparam int PFS_DUTY_LO = 6;
   localparam int PFS_CMX = 5;
   localparam int PFS_SGS_HI = 3;
   localparam int PFS_SGS_LO = 0;
   localparam int DCTL_SUPPLY = 7;
   localparam int DCTL_ACT = 6;
   localparam int DCTL_DISP = 5;
   localparam int DCTL_FSEL_HI = 1;
   localparam int DCTL_FSEL_LO = 0;
   localparam int DSUP_WAVEB = 7;
   localparam int DSUP_BIAS_OFF = 6;
   localparam int DSUP_REG_ON = 5;
   localparam int DSUP_STEP_HI = 3;
   localparam int DSUP_STEP_LO = 0;
   localparam int STAT_RUN = 7;
   localparam int STAT_PHASE = 4;

   typedef enum logic [1:0] {DUTY_STATIC, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} ldq_duty_e;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int NUM_SEG = 32;
   localparam int NUM_COM = 4;
   localparam longint CLK_HZ = 100_000_000;
   localparam longint FRAME_HZ = 64;
   localparam longint SLOT_LCM = 12;
   localparam int unsigned TICK_CYCLES = int'(CLK_HZ / (FRAME_HZ * SLOT_LCM));
   localparam logic [3:0] TICKS_STATIC = 4'hc;
   localparam logic [3:0] TICKS_HALF = 4'h6;
   localparam logic [3:0] TICKS_THIRD = 4'h4;
   localparam logic [3:0] TICKS_QUARTER = 4'h3;

endpackage

// ---- verilog/ldq_segment_lcd.sv ----
// Purpose: multiplexed segment display controller with display memory
// Assumes: inputs synchronous to clk, one-cycle strobes, read data next cycle
// Notes:   segment level is lit xor phase, selected common marked by commonOut
`timescale 1ns/100ps
`default_nettype none

module ldq_segment_lcd #(
   parameter int unsigned TickCycles = ldq_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire ldq_pkg::ldq_bus_req_s busReq,
   output logic [ldq_pkg::DATA_W-1:0] rdData,
   output logic [ldq_pkg::NUM_SEG-1:0] segmentOut,
   output logic [ldq_pkg::NUM_COM-1:0] commonOut,
   output logic acPhase,
   output logic supplyOn,
   output logic waveB,
   output logic biasConnect,
   output logic regulatorOn,
   output logic [3:0] stepUpSel
);
   import ldq_pkg::*;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] memQ [MEM_BYTES];
   logic [7:0] cfgQ [CFG_BYTES];
   logic memWe [MEM_BYTES];
   logic [7:0] memWd [MEM_BYTES];
   logic cfgWe [CFG_BYTES];
   logic [7:0] cfgWd [CFG_BYTES];
   logic [15:0] rdDataQ;
   logic [16:0] tickCntQ;
   logic [3:0] subCntQ;
   logic [1:0] slotQ;
   logic phaseQ;
   logic [NUM_SEG-1:0] segOutQ;
   logic [NUM_COM-1:0] comOutQ;
   logic phaseOutQ;

   // ----------------------------------------------------------------
   // register fields
   // ----------------------------------------------------------------
   ldq_duty_e duty;
   logic cmx, running, dispOn, tick, slotTick, parallelOk;
   logic [3:0] sgs;
   logic [1:0] fsel, lastSlot;
   logic [7:0] statusByte;
   logic [NUM_SEG-1:0] portSelVec, portDataVec, segD;
   logic [NUM_COM-1:0] comD;
   logic [16:0] tickLimit;

   assign duty = ldq_duty_e'(cfgQ[IDX_PFS][PFS_DUTY_HI:PFS_DUTY_LO]);
   assign cmx = cfgQ[IDX_PFS][PFS_CMX];
   assign sgs = cfgQ[IDX_PFS][PFS_SGS_HI:PFS_SGS_LO];
   assign running = cfgQ[IDX_DCTL][DCTL_SUPPLY] && cfgQ[IDX_DCTL][DCTL_ACT];
   assign dispOn = cfgQ[IDX_DCTL][DCTL_DISP];
   assign fsel = cfgQ[IDX_DCTL][DCTL_FSEL_HI:DCTL_FSEL_LO];
   assign lastSlot = duty;
   assign parallelOk = cmx && (duty == DUTY_STATIC || duty == DUTY_HALF);

   always_comb begin
      statusByte = 8'h00;
      statusByte[STAT_RUN] = running;
      statusByte[STAT_PHASE] = phaseQ;
      statusByte[1:0] = slotQ;
   end

   // drive-supply controls straight from their register bits
   assign supplyOn = cfgQ[IDX_DCTL][DCTL_SUPPLY];
   assign waveB = cfgQ[IDX_DSUP][DSUP_WAVEB];
   assign biasConnect = !cfgQ[IDX_DSUP][DSUP_BIAS_OFF];
   assign regulatorOn = cfgQ[IDX_DSUP][DSUP_REG_ON];
   assign stepUpSel = cfgQ[IDX_DSUP][DSUP_STEP_HI:DSUP_STEP_LO];

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic [8:0] wrByte(input ldq_bus_req_s r, input logic [15:0] a);
      logic [15:0] evenA;
      logic [8:0] res;
      evenA = {r.addr[15:1], 1'b0};
      res = 9'h000;
      if (r.wr) begin
         if (!r.word && r.addr == a) begin
            res = {1'b1, r.wdata[7:0]};
         end else if (r.word && evenA == a) begin
            res = {1'b1, r.wdata[15:8]};
         end else if (r.word && (evenA | ODD_BYTE) == a) begin
            res = {1'b1, r.wdata[7:0]};
         end
      end
      return res;
   endfunction

   function automatic logic [7:0] rdByte(input logic [15:0] a);
      logic [15:0] off;
      logic [7:0] res;
      res = 8'h00;
      off = 16'h0000;
      if (a >= MEM_BASE && a <= MEM_LAST) begin
         off = a - MEM_BASE;
         res = memQ[off[3:0]];
      end else if (a >= CFG_BASE && a <= CFG_LAST) begin
         off = a - CFG_BASE;
         res = (off[3:0] == IDX_STAT) ? statusByte : cfgQ[off[3:0]];
      end
      return res;
   endfunction

   function automatic logic [3:0] slotTicks(input ldq_duty_e d);
      logic [3:0] res;
      case (d)
         DUTY_STATIC: res = TICKS_STATIC;
         DUTY_HALF: res = TICKS_HALF;
         DUTY_THIRD: res = TICKS_THIRD;
         default: res = TICKS_QUARTER;
      endcase
      return res;
   endfunction

   // memory bit feeding segment s in slot sl
   function automatic logic litBit(input ldq_duty_e d, input logic [4:0] s, input logic [1:0] sl);
      logic [3:0] b;
      logic [2:0] k;
      case (d)
         DUTY_STATIC: begin
            b = {2'b00, s[4:3]};
            k = s[2:0];
         end
         DUTY_HALF: begin
            b = {1'b0, s[4:2]};
            k = {s[1:0], sl[0]};
         end
         default: begin
            b = s[4:1];
            k = {s[0], sl};
         end
      endcase
      return memQ[b][k];
   endfunction

   function automatic logic segLcd(input logic [3:0] g, input logic [4:0] s);
      return {g, 2'b00} > {1'b0, s};
   endfunction

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < MEM_BYTES; i++) begin
         {memWe[i], memWd[i]} = wrByte(busReq, MEM_BASE + 16'(i));
      end
      for (int i = 0; i < CFG_BYTES; i++) begin
         {cfgWe[i], cfgWd[i]} = wrByte(busReq, CFG_BASE + 16'(i));
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            memQ[i] <= MEM_RESET;
         end
      end else begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            if (memWe[i]) begin
               memQ[i] <= memWd[i];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < CFG_BYTES; i++) begin
            cfgQ[i] <= CFG_RESET;
         end
      end else begin
         for (int i = 0; i < CFG_BYTES; i++) begin
            if (cfgWe[i] && 4'(i) != IDX_STAT) begin
               cfgQ[i] <= cfgWd[i];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdDataQ <= 16'h0000;
      end else if (busReq.rd && busReq.word) begin
         rdDataQ <= {rdByte({busReq.addr[15:1], 1'b0}), rdByte({busReq.addr[15:1], 1'b1})};
      end else if (busReq.rd) begin
         rdDataQ <= {8'h00, rdByte(busReq.addr)};
      end else begin
         rdDataQ <= 16'h0000;
      end
   end

   assign rdData = rdDataQ;

   // ----------------------------------------------------------------
   // frame timing
   // ----------------------------------------------------------------
   assign tickLimit = 17'(TickCycles >> fsel) - 17'h00001;
   assign tick = running && tickCntQ >= tickLimit;
   assign slotTick = tick && subCntQ >= slotTicks(duty) - 4'h1;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tickCntQ <= 17'h00000;
      end else if (!running || tick) begin
         tickCntQ <= 17'h00000;
      end else begin
         tickCntQ <= tickCntQ + 17'h00001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         subCntQ <= 4'h0;
      end else if (!running || slotTick) begin
         subCntQ <= 4'h0;
      end else if (tick) begin
         subCntQ <= subCntQ + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slotQ <= 2'b00;
      end else if (!running) begin
         slotQ <= 2'b00;
      end else if (slotTick) begin
         slotQ <= (slotQ >= lastSlot) ? 2'b00 : slotQ + 2'b01;
      end
   end

   // waveform A flips once a frame, B once a slot
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phaseQ <= 1'b0;
      end else if (!running) begin
         phaseQ <= 1'b0;
      end else if (slotTick && (waveB || slotQ >= lastSlot)) begin
         phaseQ <= !phaseQ;
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   for (genvar s = 0; s < NUM_SEG; s++) begin : gSeg
      assign portSelVec[s] = cfgQ[IDX_PSEL + 4'(s / 8)][s % 8];
      assign portDataVec[s] = cfgQ[IDX_PDAT + 4'(s / 8)][s % 8];
      assign segD[s] = (portSelVec[s] || !segLcd(sgs, 5'(s))) ? portDataVec[s] :
                       !running ? 1'b0 :
                       ((dispOn && litBit(duty, 5'(s), slotQ)) ^ phaseQ);
   end

   for (genvar c = 0; c < NUM_COM; c++) begin : gCom
      assign comD[c] = running && ((2'(c) <= lastSlot) ? slotQ == 2'(c) :
                       (parallelOk && slotQ == ((duty == DUTY_STATIC) ? 2'b00 : 2'(c % 2))));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         segOutQ <= '0;
         comOutQ <= '0;
         phaseOutQ <= 1'b0;
      end else begin
         segOutQ <= segD;
         comOutQ <= comD;
         phaseOutQ <= running && phaseQ;
      end
   end

   assign segmentOut = segOutQ;
   assign commonOut = comOutQ;
   assign acPhase = phaseOutQ;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [19:0] gapQ;
   logic sawTickQ;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gapQ <= 20'h00000;
         sawTickQ <= 1'b0;
      end else begin
         gapQ <= slotTick ? 20'h00000 : gapQ + 20'h00001;
         sawTickQ <= busReq.wr ? 1'b0 : (sawTickQ || slotTick);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_slot_period: assert property (
      slotTick && sawTickQ && duty == DUTY_QUARTER && fsel == 2'b00
      |-> gapQ == 20'(TickCycles * 3 - 1))
      else $error("slot period wrong at quarter duty");
   chk_odd_segment: assert property (
      running && duty == DUTY_QUARTER && dispOn && !portSelVec[0] && sgs != 4'h0
      |=> segmentOut[0] == $past(memQ[0][slotQ] ^ phaseQ))
      else $error("odd segment does not follow low nibble");
   chk_even_segment: assert property (
      running && duty == DUTY_QUARTER && dispOn && !portSelVec[1] && sgs != 4'h0
      |=> segmentOut[1] == $past(memQ[0][{1'b1, slotQ}] ^ phaseQ))
      else $error("even segment does not follow high nibble");
   chk_auto_start: assert property (
      $rose(running) && duty == DUTY_QUARTER |=> commonOut == 4'h1)
      else $error("display did not start on first common");
   chk_word_write: assert property (
      busReq.wr && busReq.word && busReq.addr == MEM_BASE
      |=> memQ[0] == $past(busReq.wdata[15:8]) && memQ[1] == $past(busReq.wdata[7:0]))
      else $error("word write to display memory misplaced");
   chk_port_pin: assert property (
      portSelVec[5] |=> segmentOut[5] == $past(portDataVec[5]))
      else $error("port pin not driven from port data");
   chk_parallel_com: assert property (
      running && cmx && duty == DUTY_HALF
      |=> commonOut[2] == commonOut[0] && commonOut[3] == commonOut[1])
      else $error("paralleled commons differ");
   chk_read_config: assert property (
      busReq.rd && !busReq.word && busReq.addr == ADDR_PFS
      |=> rdData == {8'h00, $past(cfgQ[IDX_PFS])})
      else $error("config read data wrong");
   chk_halt_blank: assert property (
      !running |=> commonOut == 4'h0 && !acPhase)
      else $error("commons active while display halted");
   chk_supply_write: assert property (
      busReq.wr && !busReq.word && busReq.addr == ADDR_DSUP
      |=> waveB == $past(busReq.wdata[DSUP_WAVEB]) && regulatorOn == $past(busReq.wdata[DSUP_REG_ON]))
      else $error("drive supply register not applied");
   chk_common_rotate: assert property (
      running && duty == DUTY_QUARTER && slotTick && !busReq.wr ##1 (running && !busReq.wr)
      |=> $onehot(commonOut) && commonOut == {$past(commonOut[2:0]), $past(commonOut[3])})
      else $error("common did not advance to next line");

   cov_frame_wrap: cover property (slotTick && duty == DUTY_QUARTER && slotQ == 2'b11);
   cov_word_write: cover property (busReq.wr && busReq.word && busReq.addr == MEM_BASE);
   cov_port_pin: cover property (portSelVec[5] && running);
   cov_half_parallel: cover property (running && parallelOk && duty == DUTY_HALF);

endmodule

`default_nettype wire

// ---- bench/ldq_glass_panel.sv ----
// Purpose: passive glass model, records the lit pattern seen under each common
// Assumes: segment level is lit xor drive phase, commonOut marks the selected commons
// Notes:   slotLen holds the length of the last finished common slot
`timescale 1ns/100ps
`default_nettype none

module ldq_glass_panel (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ldq_pkg::NUM_SEG-1:0] segmentOut,
   input wire logic [ldq_pkg::NUM_COM-1:0] commonOut,
   input wire logic acPhase,
   output logic [ldq_pkg::NUM_COM-1:0][ldq_pkg::NUM_SEG-1:0] litMap,
   output logic [15:0] slotLen
);
   import ldq_pkg::*;

   logic [NUM_COM-1:0] prevCom;
   logic [15:0] runLen;

   // ----------------------------------------------------------------
   // lit pattern per selected common
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         litMap <= '0;
      end else begin
         for (int c = 0; c < NUM_COM; c++) begin
            if (commonOut[c]) begin
               litMap[c] <= segmentOut ^ {NUM_SEG{acPhase}};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // slot length
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prevCom <= '0;
         runLen <= 16'h0001;
         slotLen <= 16'h0000;
      end else begin
         prevCom <= commonOut;
         if (commonOut != prevCom) begin
            slotLen <= runLen;
            runLen <= 16'h0001;
         end else begin
            runLen <= runLen + 16'h0001;
         end
      end
   end

endmodule
`default_nettype wire

// ---- bench/ldq_segment_lcd_bench.sv ----
// Purpose: self-checking bench of the segment display driver
// Assumes: short prescaler, slot of 3*TickT cycles at 1/4 duty
// Notes:   register port driven by tasks, glass model watches the pins
`timescale 1ns/100ps
`default_nettype none

module ldq_segment_lcd_bench;
   import ldq_pkg::*;

   localparam int unsigned TickT = 8;
   localparam int FrameCyc = 96;

   logic clk;
   logic rst;
   ldq_bus_req_s busReq;
   logic [DATA_W-1:0] rdData;
   logic [NUM_SEG-1:0] segmentOut;
   logic [NUM_COM-1:0] commonOut;
   logic acPhase, supplyOn, waveB, biasConnect, regulatorOn;
   logic [3:0] stepUpSel;
   logic [NUM_COM-1:0][NUM_SEG-1:0] litMap;
   logic [15:0] slotLen;
   logic [7:0] img [0:7];
   int errors = 0;
   int compares = 0;
   int bad;

   ldq_segment_lcd #(.TickCycles(TickT)) uut (.clk(clk), .rst(rst), .busReq(busReq),
      .rdData(rdData), .segmentOut(segmentOut), .commonOut(commonOut), .acPhase(acPhase),
      .supplyOn(supplyOn), .waveB(waveB), .biasConnect(biasConnect),
      .regulatorOn(regulatorOn), .stepUpSel(stepUpSel));

   ldq_glass_panel panel (.clk(clk), .rst(rst), .segmentOut(segmentOut),
      .commonOut(commonOut), .acPhase(acPhase), .litMap(litMap), .slotLen(slotLen));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, word: w};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] e, input string nm);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, word: w};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1;
      chk(nm, e, rdData);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chkRows(input logic quarter);
      logic [15:0] e;
      for (int c = 0; c < (quarter ? 4 : 2); c++) begin
         for (int s = 0; s < 16; s++) begin
            e[s] = quarter ? img[s/2][(s%2)*4+c] : img[s/4][(s%4)*2+c];
         end
         chk("litRow", e, litMap[c][15:0]);
      end
   endtask

   task automatic finish_test;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock, reset, watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("BAD watchdog expected done seen hang");
      finish_test();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      busReq = '0;
      img = '{8'h17, 8'hf5, 8'hb5, 8'h36, 8'ha7, 8'he3, 8'h06, 8'hd7};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("biasReset", 16'h0001, {15'h0, biasConnect});
      rd(ADDR_PFS, 1'b0, 16'h0000, "pfsReset");
      rd(16'hffa1, 1'b0, 16'h0000, "dctlReset");
      rd(ADDR_DSUP, 1'b0, 16'h0000, "dsupReset");
      wr(ADDR_DSUP, 16'h00a5, 1'b0);
      rd(ADDR_DSUP, 1'b0, 16'h00a5, "dsupBack");
      chk("supplyPins", 16'h00e5, {8'h00, waveB, biasConnect, regulatorOn, 1'b0, stepUpSel});
      wr(ADDR_DSUP, 16'h0040, 1'b0);
      cyc(1);
      chk("biasOff", 16'h0000, {14'h0, waveB, biasConnect});
      wr(16'hf378, 16'h1234, 1'b1);
      rd(16'hf379, 1'b0, 16'h0034, "memOddByte");
      rd(16'hf378, 1'b0, 16'h0012, "memEvenByte");
      wr(16'hf37f, 16'h00ab, 1'b0);
      rd(16'hf37e, 1'b1, 16'h00ab, "memWord");
      wr(16'h1000, 16'hffff, 1'b1);
      rd(16'h1000, 1'b1, 16'h0000, "unmapped");
      wr(16'hffa3, 16'h00ff, 1'b0);
      rd(16'hffa3, 1'b0, 16'h0000, "statusIdle");
      // 1/4 duty, 16 segments, memory written after display starts
      wr(ADDR_PFS, 16'h00c4, 1'b0);
      wr(16'hffa1, 16'h00e0, 1'b0);
      cyc(1);
      chk("firstCommon", 16'h0001, {12'h0, commonOut});
      rd(16'hffa1, 1'b0, 16'h00e0, "dctlBack");
      rd(ADDR_PFS, 1'b0, 16'h00c4, "pfsBack");
      for (int k = 0; k < 4; k++) begin
         wr(MEM_BASE + 16'(2*k), {img[2*k], img[2*k+1]}, 1'b1);
      end
      rd(16'hf373, 1'b0, {8'h00, img[3]}, "memPair");
      cyc(4 * FrameCyc);
      chkRows(1'b1);
      chk("quarterSlot", 16'(3 * TickT), slotLen);
      wr(16'hffa1, 16'h00e1, 1'b0);
      cyc(2 * FrameCyc);
      chk("fastSlot", 16'(3 * TickT / 2), slotLen);
      // 1/2 duty remaps memory
      wr(16'hffa1, 16'h00e0, 1'b0);
      wr(ADDR_PFS, 16'h0044, 1'b0);
      cyc(4 * FrameCyc);
      chkRows(1'b0);
      chk("halfSlot", 16'(6 * TickT), slotLen);
      wr(ADDR_PFS, 16'h0064, 1'b0);
      bad = 0;
      repeat (200) begin
         cyc(1);
         if (commonOut[3:2] !== commonOut[1:0] || commonOut[1:0] === 2'b00) begin
            bad++;
         end
      end
      chk("parallelCom", 16'h0000, bad[15:0]);
      // 1/3 duty slot length, static duty with all commons paralleled
      wr(ADDR_PFS, 16'h0084, 1'b0);
      cyc(4 * FrameCyc);
      chk("thirdSlot", 16'(4 * TickT), slotLen);
      wr(ADDR_PFS, 16'h0024, 1'b0);
      cyc(2 * FrameCyc);
      chk("staticCom", 16'h000f, {12'h0, commonOut});
      // display data off blanks every crossing
      wr(ADDR_PFS, 16'h00c4, 1'b0);
      wr(16'hffa1, 16'h00c0, 1'b0);
      cyc(4 * FrameCyc);
      for (int c = 0; c < 4; c++) begin
         chk("blankRow", 16'h0000, litMap[c][15:0]);
      end
      // halted display
      wr(16'hffa1, 16'h0080, 1'b0);
      cyc(2);
      chk("haltCom", 16'h0010, {10'h0, acPhase, supplyOn, commonOut});
      chk("haltSeg", 16'h0000, segmentOut[15:0]);
      // port pins
      wr(16'hffa4, 16'h0001, 1'b0);
      wr(16'hffa8, 16'h0001, 1'b0);
      wr(16'hffaa, 16'hc35a, 1'b1);
      rd(16'hffa4, 1'b0, 16'h0001, "portSelBack");
      cyc(2);
      chk("portLow", 16'h0001, segmentOut[15:0]);
      chk("portHigh", 16'h5ac3, segmentOut[31:16]);
      finish_test();
   end

endmodule
`default_nettype wire
